// ===== dmmd_map.sv
/*
 memory map decoder top: decodes core and DMA accesses, stalls DMA on bank
 collisions, holds map control in AXI4-Lite registers.
 assumes requesters hold a stalled DMA access and share clk_in and rst_in.
*/
`timescale 1ns/1ps
`include "dmmd_regs.svh"
module dmmd_map import dmmd_pkg::*; #(
	parameter int X_RAM_WORDS = 65536,
	parameter int Y_RAM_WORDS = 65536,
	parameter int P_RAM_WORDS = 32768,
	parameter int X_ROM_BANKS = 30,
	parameter int Y_ROM_BANKS = 30,
	parameter int P_ROM_BANKS = 32,
	parameter bit BOOT_BIG = 1'b0,
	parameter bit X_IO_INT = 1'b1,
	parameter bit Y_IO_INT = 1'b1,
	parameter logic [7:0] Y_SEG_INT = 8'hFF,
	parameter int NUM_SW_MODES = 4,
	parameter int SW_STEP = 4096
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// core access
	input wire logic core_valid_in,
	input wire dmmd_space_t core_space_in,
	input wire logic [23:0] core_addr_in,
	// dma access
	input wire logic dma_valid_in,
	input wire dmmd_space_t dma_space_in,
	input wire logic [23:0] dma_addr_in,
	// decode results
	output dmmd_region_t core_region_out,
	output logic [4:0] core_bank_out,
	output dmmd_region_t dma_region_out,
	output logic [4:0] dma_bank_out,
	output logic dma_stall_out,
	output logic dma_refused_out,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef struct packed {
		logic awrdy;
		logic wrdy;
		logic bvld;
		logic [1:0] bresp;
		logic arrdy;
		logic rvld;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic wstrb0;
		logic ce;
		logic sc;
		logic [2:0] sw;
		logic [15:0] stalls;
		logic [15:0] refused;
		dmmd_region_t c_rgn;
		logic [4:0] c_bank;
		dmmd_region_t d_rgn;
		logic [4:0] d_bank;
		logic stall;
		logic refuse;
	} dmmd_state_t;

	// switch mode count must be 4 to 8 and device boundaries must fit the 16-bit internal window
	if (NUM_SW_MODES < 4 || NUM_SW_MODES > 8) begin : g_bad_sw
		$error("switch mode count must be 4 to 8");
	end
	if (P_RAM_WORDS + (NUM_SW_MODES - 1) * SW_STEP + `DMMD_CACHE_WORDS > 65536 ||
		X_RAM_WORDS < (NUM_SW_MODES - 1) * SW_STEP || X_RAM_WORDS > 65536 ||
		Y_RAM_WORDS > 65536 || X_ROM_BANKS > 30 || Y_ROM_BANKS > 30 ||
		P_ROM_BANKS > 32) begin : g_bad_map
		$error("internal memory does not fit its window");
	end

	dmmd_state_t s_r;
	dmmd_state_t s_nxt;
	dmmd_region_t c_rgn;
	dmmd_region_t d_rgn;
	logic [4:0] c_bank;
	logic [4:0] d_bank;
	logic collide;

	////////////////////////////////////////////////////////////////////////////
	dmmd_decode #(
		.X_RAM_WORDS(X_RAM_WORDS), .Y_RAM_WORDS(Y_RAM_WORDS), .P_RAM_WORDS(P_RAM_WORDS),
		.X_ROM_BANKS(X_ROM_BANKS), .Y_ROM_BANKS(Y_ROM_BANKS), .P_ROM_BANKS(P_ROM_BANKS),
		.BOOT_BIG(BOOT_BIG), .X_IO_INT(X_IO_INT), .Y_IO_INT(Y_IO_INT),
		.Y_SEG_INT(Y_SEG_INT), .SW_STEP(SW_STEP)
	) u_core_dec (
		.space_in(core_space_in),
		.addr_in(core_addr_in),
		.dma_in(1'b0),
		.ce_in(s_r.ce),
		.sc_in(s_r.sc),
		.sw_in(s_r.sw),
		.region_out(c_rgn),
		.bank_out(c_bank)
	);

	dmmd_decode #(
		.X_RAM_WORDS(X_RAM_WORDS), .Y_RAM_WORDS(Y_RAM_WORDS), .P_RAM_WORDS(P_RAM_WORDS),
		.X_ROM_BANKS(X_ROM_BANKS), .Y_ROM_BANKS(Y_ROM_BANKS), .P_ROM_BANKS(P_ROM_BANKS),
		.BOOT_BIG(BOOT_BIG), .X_IO_INT(X_IO_INT), .Y_IO_INT(Y_IO_INT),
		.Y_SEG_INT(Y_SEG_INT), .SW_STEP(SW_STEP)
	) u_dma_dec (
		.space_in(dma_space_in),
		.addr_in(dma_addr_in),
		.dma_in(1'b1),
		.ce_in(s_r.ce),
		.sc_in(s_r.sc),
		.sw_in(s_r.sw),
		.region_out(d_rgn),
		.bank_out(d_bank)
	);

	function automatic logic is_bank(input dmmd_region_t r);
		is_bank = (r == DMMD_RG_RAM) || (r == DMMD_RG_ROM);
	endfunction : is_bank

	// first external program word: RAM, switch share, and cache when disabled
	function automatic logic [23:0] ext_p_start(input logic ce, input logic [2:0] sw);
		logic [31:0] v;
		v = 32'(P_RAM_WORDS) + 32'(sw) * 32'(SW_STEP);
		if (!ce) begin
			v = v + 32'(`DMMD_CACHE_WORDS);
		end
		ext_p_start = v[23:0];
	endfunction : ext_p_start

	function automatic logic [32:0] rd_word(input dmmd_state_t st, input logic [7:0] a);
		case (a)
			`DMMD_OFS_CTRL: rd_word = {1'b1, 25'h0000000, st.sw, 2'h0, st.sc, st.ce};
			`DMMD_OFS_EXTP: rd_word = {1'b1, 8'h00, ext_p_start(st.ce, st.sw)};
			`DMMD_OFS_STALLS: rd_word = {1'b1, 16'h0000, st.stalls};
			`DMMD_OFS_REFUSED: rd_word = {1'b1, 16'h0000, st.refused};
			default: rd_word = {1'b0, 32'h00000000};
		endcase
	endfunction : rd_word

	////////////////////////////////////////////////////////////////////////////
	// same space, same bank: core keeps the slot, DMA waits for a free one
	assign collide = core_valid_in && dma_valid_in && core_space_in == dma_space_in &&
		is_bank(c_rgn) && c_rgn == d_rgn && c_bank == d_bank;

	always_comb begin
		logic [32:0] rw;
		rw = 33'h000000000;
		s_nxt = s_r;
		// decode stage
		s_nxt.c_rgn = core_valid_in ? c_rgn : DMMD_RG_NONE;
		s_nxt.c_bank = core_valid_in ? c_bank : 5'h00;
		s_nxt.d_rgn = dma_valid_in ? d_rgn : DMMD_RG_NONE;
		s_nxt.d_bank = dma_valid_in ? d_bank : 5'h00;
		s_nxt.stall = collide;
		s_nxt.refuse = dma_valid_in && d_rgn == DMMD_RG_REFUSED;
		if (collide && s_r.stalls != 16'hFFFF) begin
			s_nxt.stalls = s_r.stalls + 16'h0001;
		end
		if (s_nxt.refuse && s_r.refused != 16'hFFFF) begin
			s_nxt.refused = s_r.refused + 16'h0001;
		end
		// write channel: address and data taken in either order
		if (s_r.awrdy && s_axi_awvalid) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_r.wrdy && s_axi_wvalid) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb0 = s_axi_wstrb[0];
		end
		if (s_r.bvld && s_axi_bready) begin
			s_nxt.bvld = 1'b0;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvld) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvld = 1'b1;
			s_nxt.bresp = `DMMD_RESP_OKAY;
			if (s_r.awaddr == `DMMD_OFS_CTRL) begin
				if (s_r.wstrb0) begin
					s_nxt.ce = s_r.wdata[`DMMD_CTRL_CE];
					s_nxt.sc = s_r.wdata[`DMMD_CTRL_SC];
					// an unsupported switch mode keeps the old one
					if (32'(s_r.wdata[`DMMD_CTRL_SW_LSB +: 3]) < 32'(NUM_SW_MODES)) begin
						s_nxt.sw = s_r.wdata[`DMMD_CTRL_SW_LSB +: 3];
					end
				end
			end else begin
				rw = rd_word(s_r, s_r.awaddr);
				if (!rw[32]) begin
					s_nxt.bresp = `DMMD_RESP_SLVERR;
				end
			end
		end
		s_nxt.awrdy = !s_nxt.aw_got && !s_nxt.bvld;
		s_nxt.wrdy = !s_nxt.w_got && !s_nxt.bvld;
		// read channel
		if (s_r.rvld && s_axi_rready) begin
			s_nxt.rvld = 1'b0;
		end
		if (s_r.arrdy && s_axi_arvalid) begin
			rw = rd_word(s_r, s_axi_araddr);
			s_nxt.rvld = 1'b1;
			s_nxt.rdata = rw[31:0];
			s_nxt.rresp = rw[32] ? `DMMD_RESP_OKAY : `DMMD_RESP_SLVERR;
		end
		s_nxt.arrdy = !s_nxt.rvld;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_r <= '0;
			{s_r.sw, s_r.sc, s_r.ce} <= `DMMD_CTRL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign core_region_out = s_r.c_rgn;
	assign core_bank_out = s_r.c_bank;
	assign dma_region_out = s_r.d_rgn;
	assign dma_bank_out = s_r.d_bank;
	assign dma_stall_out = s_r.stall;
	assign dma_refused_out = s_r.refuse;
	assign s_axi_awready = s_r.awrdy;
	assign s_axi_wready = s_r.wrdy;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_bvalid = s_r.bvld;
	assign s_axi_arready = s_r.arrdy;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rvalid = s_r.rvld;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// boot end as built, so rom checks start where the boot rom stops
	localparam logic [23:0] BOOT_LAST = BOOT_BIG ? `DMMD_BOOT_BIG_HI : `DMMD_BOOT_SMALL_HI;

	a_stall_same_bank: assert property (
		dma_stall_out |-> is_bank(dma_region_out) && core_region_out == dma_region_out &&
			core_bank_out == dma_bank_out)
		else $error("dma stalled without a bank collision");
	a_no_stall_apart: assert property (
		core_valid_in && dma_valid_in && core_space_in == dma_space_in &&
		core_addr_in[23:11] != dma_addr_in[23:11] && !s_r.sc |=> !dma_stall_out)
		else $error("dma stalled on different banks");
	a_boot_dma_refuse: assert property (
		dma_valid_in && dma_space_in == DMMD_SP_P && dma_addr_in >= `DMMD_ROM_LO &&
		dma_addr_in <= `DMMD_BOOT_SMALL_HI |=> dma_refused_out && !dma_stall_out)
		else $error("dma reached the boot rom");
	a_boot_core_ok: assert property (
		core_valid_in && core_space_in == DMMD_SP_P && core_addr_in >= `DMMD_ROM_LO &&
		core_addr_in <= `DMMD_BOOT_SMALL_HI |=> core_region_out == DMMD_RG_BOOT)
		else $error("core boot fetch misrouted");
	a_x_top_regs: assert property (
		core_valid_in && core_space_in == DMMD_SP_X && core_addr_in >= `DMMD_IO_TOP
		|=> core_region_out == DMMD_RG_PERIPH)
		else $error("x top page not on-chip");
	a_cache_hidden: assert property (
		s_r.ce && core_valid_in && core_space_in == DMMD_SP_P &&
		32'(core_addr_in) >= 32'(ext_p_start(1'b1, s_r.sw)) &&
		32'(core_addr_in) < 32'(ext_p_start(1'b0, s_r.sw)) ##1 $stable(s_r.ce)
		|-> core_region_out == DMMD_RG_EXT)
		else $error("enabled cache still visible");
	a_cache_as_ram: assert property (
		!s_r.ce && core_valid_in && core_space_in == DMMD_SP_P &&
		32'(core_addr_in) >= 32'(ext_p_start(1'b1, s_r.sw)) &&
		32'(core_addr_in) < 32'(ext_p_start(1'b0, s_r.sw)) ##1 $stable(s_r.ce)
		|-> core_region_out == DMMD_RG_RAM)
		else $error("disabled cache not program ram");
	a_y_segments: assert property (
		core_valid_in && core_space_in == DMMD_SP_Y && core_addr_in >= `DMMD_IO_TOP
		|=> core_region_out == (Y_SEG_INT[$past(core_addr_in[6:4])] ?
			DMMD_RG_PERIPH : DMMD_RG_EXT))
		else $error("y io segment misrouted");
	a_ctrl_write: assert property (
		s_r.aw_got && s_r.w_got && !s_r.bvld && s_r.awaddr == `DMMD_OFS_CTRL && s_r.wstrb0
		|=> s_r.sc == $past(s_r.wdata[`DMMD_CTRL_SC]) && s_axi_bvalid)
		else $error("control write lost");
	a_bresp_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_idle_no_stall: assert property (
		!dma_valid_in |=> !dma_stall_out && dma_region_out == DMMD_RG_NONE)
		else $error("idle dma stalled");
	a_refuse_region: assert property (
		dma_refused_out |-> dma_region_out == DMMD_RG_REFUSED && !dma_stall_out)
		else $error("refused dma still routed");
	a_sw_supported: assert property (
		32'(s_r.sw) < 32'(NUM_SW_MODES))
		else $error("unsupported switch mode active");
	a_x_io_switch: assert property (
		core_valid_in && core_space_in == DMMD_SP_X && core_addr_in >= `DMMD_SW_IO_LO &&
		core_addr_in < `DMMD_IO_TOP
		|=> core_region_out == (X_IO_INT ? DMMD_RG_PERIPH : DMMD_RG_EXT))
		else $error("x switchable io misrouted");
	a_x_rom_bank: assert property (
		core_valid_in && core_space_in == DMMD_SP_X && core_addr_in >= `DMMD_ROM_LO &&
		core_addr_in < `DMMD_SW_IO_LO
		|=> core_region_out == (32'(core_bank_out) < 32'(X_ROM_BANKS) ?
			DMMD_RG_ROM : DMMD_RG_EXT))
		else $error("x rom bank misrouted");
	a_p_rom_bank: assert property (
		core_valid_in && core_space_in == DMMD_SP_P && core_addr_in > BOOT_LAST
		|=> core_region_out == (32'(core_bank_out) < 32'(P_ROM_BANKS) ?
			DMMD_RG_ROM : DMMD_RG_EXT))
		else $error("program rom bank misrouted");
	a_x_ram: assert property (
		core_valid_in && core_space_in == DMMD_SP_X && !s_r.sc &&
		32'(core_addr_in) < 32'(X_RAM_WORDS) - 32'(s_r.sw) * 32'(SW_STEP)
		|=> core_region_out == DMMD_RG_RAM && core_bank_out == $past(core_addr_in[15:11]))
		else $error("x internal ram misrouted");
	a_y_ram: assert property (
		core_valid_in && core_space_in == DMMD_SP_Y && !s_r.sc &&
		32'(core_addr_in) < 32'(Y_RAM_WORDS)
		|=> core_region_out == DMMD_RG_RAM)
		else $error("y internal ram misrouted");
	a_p_ram: assert property (
		core_valid_in && core_space_in == DMMD_SP_P &&
		32'(core_addr_in) < 32'(P_RAM_WORDS) + 32'(s_r.sw) * 32'(SW_STEP)
		|=> core_region_out == DMMD_RG_RAM)
		else $error("program ram misrouted");
	a_ext_gap: assert property (
		core_valid_in && core_space_in inside {DMMD_SP_X, DMMD_SP_Y, DMMD_SP_P} &&
		core_addr_in[23:16] != 8'h00 && core_addr_in[23:16] != 8'hFF
		|=> core_region_out == DMMD_RG_EXT)
		else $error("unclaimed address not external");

	c_collision: cover property (dma_stall_out ##1 !dma_stall_out && dma_region_out != DMMD_RG_NONE);
	c_parallel: cover property (is_bank(core_region_out) && is_bank(dma_region_out) &&
		!dma_stall_out);
	c_refused: cover property (dma_refused_out);
	c_cache_on: cover property (s_r.ce && core_region_out == DMMD_RG_EXT);
	c_compat: cover property (s_r.sc && core_region_out == DMMD_RG_PERIPH);
endmodule : dmmd_map

// ===== dmmd_regs.svh
/*
 memory map decoder constants: map boundaries, register offsets, reset values.
 assumes a 24-bit word address per space and a 32-bit AXI4-Lite register bus.
*/
`ifndef DMMD_REGS_SVH
`define DMMD_REGS_SVH

`define DMMD_IO_TOP 24'hFFFF80
`define DMMD_SW_IO_LO 24'hFFF000
`define DMMD_ROM_LO 24'hFF0000
`define DMMD_INT_HI 24'h00FFFF
`define DMMD_BOOT_SMALL_HI 24'hFF00BF
`define DMMD_BOOT_BIG_HI 24'hFF0C00
`define DMMD_PROM_LO 24'hFF00C0
`define DMMD_BANK_WORDS 2048
`define DMMD_BANK_LSB 11
`define DMMD_SEG_LSB 4
`define DMMD_CACHE_WORDS 1024
`define DMMD_SC_PAGE 4'hF
`define DMMD_SC_HI 8'hFF

`define DMMD_OFS_CTRL 8'h00
`define DMMD_OFS_EXTP 8'h04
`define DMMD_OFS_STALLS 8'h08
`define DMMD_OFS_REFUSED 8'h0C
`define DMMD_CTRL_CE 0
`define DMMD_CTRL_SC 1
`define DMMD_CTRL_SW_LSB 4
`define DMMD_CTRL_RST 5'h00
`define DMMD_RESP_OKAY 2'h0
`define DMMD_RESP_SLVERR 2'h2

`endif

// ===== dmmd_pkg.sv
/*
 types of the memory map decoder: spaces and decode targets.
 assumes dmmd_regs.svh for all numeric constants.
*/
package dmmd_pkg;
	typedef enum logic [1:0] {
		DMMD_SP_X = 2'h0,
		DMMD_SP_Y = 2'h1,
		DMMD_SP_P = 2'h2
	} dmmd_space_t;

	typedef enum logic [2:0] {
		DMMD_RG_NONE = 3'h0,
		DMMD_RG_RAM = 3'h1,
		DMMD_RG_ROM = 3'h2,
		DMMD_RG_PERIPH = 3'h3,
		DMMD_RG_BOOT = 3'h4,
		DMMD_RG_EXT = 3'h5,
		DMMD_RG_REFUSED = 3'h6
	} dmmd_region_t;
endpackage : dmmd_pkg

// ===== dmmd_decode.sv
/*
 combinational address decode of one access into a target region and bank.
 assumes control bits come from registers on the same clock as the access.
*/
`timescale 1ns/1ps
`include "dmmd_regs.svh"
module dmmd_decode import dmmd_pkg::*; #(
	parameter int X_RAM_WORDS = 65536,
	parameter int Y_RAM_WORDS = 65536,
	parameter int P_RAM_WORDS = 32768,
	parameter int X_ROM_BANKS = 30,
	parameter int Y_ROM_BANKS = 30,
	parameter int P_ROM_BANKS = 32,
	parameter bit BOOT_BIG = 1'b0,
	parameter bit X_IO_INT = 1'b1,
	parameter bit Y_IO_INT = 1'b1,
	parameter logic [7:0] Y_SEG_INT = 8'hFF,
	parameter int SW_STEP = 4096
) (
	// access
	input wire dmmd_space_t space_in,
	input wire logic [23:0] addr_in,
	input wire logic dma_in,
	// map control
	input wire logic ce_in,
	input wire logic sc_in,
	input wire logic [2:0] sw_in,
	// result
	output dmmd_region_t region_out,
	output logic [4:0] bank_out
);
	logic [23:0] ea;
	logic [31:0] ea32;
	logic [31:0] xtop;
	logic [31:0] ytop;
	logic [31:0] ptop;
	logic [23:0] boot_hi;

	always_comb begin
		// compatibility map folds the 16-bit io page onto the top page
		ea = addr_in;
		if (sc_in && space_in != DMMD_SP_P && addr_in[23:16] == 8'h00 &&
			addr_in[15:12] == `DMMD_SC_PAGE) begin
			ea = {`DMMD_SC_HI, addr_in[15:0]};
		end
		ea32 = {8'h00, ea};
		// switch modes move banks from X data to program RAM
		xtop = 32'(X_RAM_WORDS) - 32'(sw_in) * 32'(SW_STEP);
		ytop = 32'(Y_RAM_WORDS);
		ptop = 32'(P_RAM_WORDS) + 32'(sw_in) * 32'(SW_STEP);
		if (!ce_in) begin
			ptop = ptop + 32'(`DMMD_CACHE_WORDS);
		end
		boot_hi = BOOT_BIG ? `DMMD_BOOT_BIG_HI : `DMMD_BOOT_SMALL_HI;
		bank_out = ea[`DMMD_BANK_LSB +: 5];
		region_out = DMMD_RG_EXT;
		case (space_in)
			DMMD_SP_X: begin
				if (ea >= `DMMD_IO_TOP) begin
					region_out = DMMD_RG_PERIPH;
				end else if (ea >= `DMMD_SW_IO_LO) begin
					region_out = X_IO_INT ? DMMD_RG_PERIPH : DMMD_RG_EXT;
				end else if (ea >= `DMMD_ROM_LO) begin
					if (32'(bank_out) < 32'(X_ROM_BANKS)) begin
						region_out = DMMD_RG_ROM;
					end
				end else if (ea <= `DMMD_INT_HI && ea32 < xtop) begin
					region_out = DMMD_RG_RAM;
				end
			end
			DMMD_SP_Y: begin
				if (ea >= `DMMD_IO_TOP) begin
					if (Y_SEG_INT[ea[`DMMD_SEG_LSB +: 3]]) begin
						region_out = DMMD_RG_PERIPH;
					end
				end else if (ea >= `DMMD_SW_IO_LO) begin
					region_out = Y_IO_INT ? DMMD_RG_PERIPH : DMMD_RG_EXT;
				end else if (ea >= `DMMD_ROM_LO) begin
					if (32'(bank_out) < 32'(Y_ROM_BANKS)) begin
						region_out = DMMD_RG_ROM;
					end
				end else if (ea <= `DMMD_INT_HI && ea32 < ytop) begin
					region_out = DMMD_RG_RAM;
				end
			end
			DMMD_SP_P: begin
				if (ea >= `DMMD_ROM_LO && ea <= boot_hi) begin
					region_out = dma_in ? DMMD_RG_REFUSED : DMMD_RG_BOOT;
				end else if (ea >= `DMMD_PROM_LO) begin
					if (32'(bank_out) < 32'(P_ROM_BANKS)) begin
						region_out = DMMD_RG_ROM;
					end
				end else if (ea <= `DMMD_INT_HI && ea32 < ptop) begin
					region_out = DMMD_RG_RAM;
				end
			end
			default: begin
				region_out = DMMD_RG_NONE;
			end
		endcase
	end
endmodule : dmmd_decode

// ===== dmmd_dma_model.sv
/*
 dma engine model: presents one access and holds it while the decoder stalls it.
 assumes dmmd_map on the same clock, with stall registered one edge after sampling.
*/
`timescale 1ns/1ps
module dmmd_dma_model import dmmd_pkg::*; (
	// clock and command
	input wire logic clk_in,
	input wire logic go_in,
	input wire dmmd_space_t space_in,
	input wire logic [23:0] addr_in,
	// decoder answer
	input wire logic stall_in,
	input wire dmmd_region_t region_in,
	input wire logic [4:0] bank_in,
	input wire logic refused_in,
	// access and outcome
	output logic valid_out,
	output dmmd_space_t space_out,
	output logic [23:0] addr_out,
	output int waits_out,
	output dmmd_region_t served_out,
	output logic [4:0] served_bank_out,
	output logic served_refused_out
);
	initial begin
		valid_out = 1'b0;
		space_out = DMMD_SP_X;
		addr_out = 24'h000000;
		waits_out = 0;
		served_out = DMMD_RG_NONE;
		served_bank_out = 5'h00;
		served_refused_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////
	// stall shows one edge late, so the decision waits just past the edge
	always @(posedge clk_in) begin
		if (go_in && !valid_out) begin
			valid_out <= 1'b1;
			space_out <= space_in;
			addr_out <= addr_in;
			waits_out <= 0;
		end else if (valid_out) begin
			#1;
			if (stall_in) begin
				waits_out <= waits_out + 1;
			end else begin
				valid_out <= 1'b0;
				served_out <= region_in;
				served_bank_out <= bank_in;
				served_refused_out <= refused_in;
				// released lines must not keep showing the old address
				addr_out <= ~addr_out;
			end
		end
	end
endmodule : dmmd_dma_model

// ===== dmmd_map_tb_top.sv
/*
 testbench of the memory map decoder: map table, control registers, dma collisions.
 assumes dmmd_map with one clock, registered outputs and an AXI4-Lite slave.
*/
`timescale 1ns/1ps
module dmmd_map_tb_top;
	import dmmd_pkg::*;
	typedef struct packed {
		logic [1:0] sp;
		logic [23:0] a;
		logic [2:0] r;
		logic [4:0] b;
		logic [2:0] r2;
	} dmmd_case_t;
	// second instance: big boot, both io windows external, only y segment 0 on-chip
	localparam dmmd_case_t MAP [18] = '{
		'{2'h0, 24'h00FFFF, 3'h1, 5'h1F, 3'h1},
		'{2'h0, 24'h010000, 3'h5, 5'h00, 3'h5},
		'{2'h0, 24'hFFE800, 3'h2, 5'h1D, 3'h2},
		'{2'h0, 24'hFFF000, 3'h3, 5'h00, 3'h5},
		'{2'h0, 24'hFFFF80, 3'h3, 5'h00, 3'h3},
		'{2'h1, 24'h000000, 3'h1, 5'h00, 3'h1},
		'{2'h1, 24'hFF0800, 3'h2, 5'h01, 3'h2},
		'{2'h1, 24'hFFF000, 3'h3, 5'h00, 3'h5},
		'{2'h1, 24'hFFFF80, 3'h3, 5'h00, 3'h3},
		'{2'h1, 24'hFFFF90, 3'h3, 5'h00, 3'h5},
		'{2'h2, 24'h007FFF, 3'h1, 5'h0F, 3'h1},
		'{2'h2, 24'h008000, 3'h1, 5'h10, 3'h1},
		'{2'h2, 24'h008400, 3'h5, 5'h00, 3'h5},
		'{2'h2, 24'hFF00BF, 3'h4, 5'h00, 3'h4},
		'{2'h2, 24'hFF00C0, 3'h2, 5'h00, 3'h4},
		'{2'h2, 24'hFF0C00, 3'h2, 5'h01, 3'h4},
		'{2'h2, 24'hFFFFFF, 3'h2, 5'h1F, 3'h2},
		'{2'h3, 24'h000000, 3'h0, 5'h00, 3'h0}
	};
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic core_valid_in = 1'b0;
	dmmd_space_t core_space_in = DMMD_SP_X;
	logic [23:0] core_addr_in = 24'h000000;
	logic go = 1'b0;
	dmmd_space_t go_space = DMMD_SP_X;
	logic [23:0] go_addr = 24'h000000;
	logic dma_valid_in;
	dmmd_space_t dma_space_in;
	logic [23:0] dma_addr_in;
	int waits;
	logic [4:0] sbank;
	logic srefused;
	dmmd_region_t served, core_region_out, dma_region_out, region2;
	logic [4:0] core_bank_out, dma_bank_out;
	logic dma_stall_out, dma_refused_out;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int errors = 0;
	int comparisons = 0;
	always #20 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////////////////
	dmmd_map dmmd_map_i (.*);
	dmmd_map #(.BOOT_BIG(1'b1), .X_IO_INT(1'b0), .Y_IO_INT(1'b0), .Y_SEG_INT(8'h01))
	dmmd_map_alt_i (.*, .core_region_out(region2), .core_bank_out(), .dma_region_out(),
		.dma_bank_out(), .dma_stall_out(), .dma_refused_out(), .s_axi_awready(),
		.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_arready(),
		.s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid());
	dmmd_dma_model dmmd_dma_model_i (.clk_in(clk_in), .go_in(go), .space_in(go_space),
		.addr_in(go_addr), .stall_in(dma_stall_out), .region_in(dma_region_out),
		.bank_in(dma_bank_out), .refused_in(dma_refused_out),
		.valid_out(dma_valid_in), .space_out(dma_space_in), .addr_out(dma_addr_in),
		.waits_out(waits), .served_out(served), .served_bank_out(sbank),
		.served_refused_out(srefused));
	////////////////////////////////////////////////////////////////////////////
	task give_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task tmo;
		errors++;
		$display("CHECK FAILED at %0t ns: wait ran out, got %h expected %h", $time, 0, 1);
		give_verdict();
	endtask : tmo
	task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_in);
			if (s_axi_awready === 1'b1 && s_axi_awvalid) begin
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready === 1'b1 && s_axi_wvalid) begin
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid === 1'b1) begin
				break;
			end
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 50) tmo();
	endtask : axw
	task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_in);
			if (s_axi_arready === 1'b1 && s_axi_arvalid) begin
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid === 1'b1) begin
				break;
			end
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n == 50) tmo();
	endtask : axr
	// one core access; outputs are settled 1 ns after the sampling edge
	task cacc(input logic [1:0] s, input logic [23:0] a);
		@(posedge clk_in);
		core_valid_in <= 1'b1;
		core_space_in <= dmmd_space_t'(s);
		core_addr_in <= a;
		@(posedge clk_in);
		core_valid_in <= 1'b0;
		core_addr_in <= ~a;
		#1;
	endtask : cacc
	////////////////////////////////////////////////////////////////////////////
	task t_map;
		int i;
		for (i = 0; i < 18; i++) begin
			cacc(MAP[i].sp, MAP[i].a);
			chk(core_region_out, MAP[i].r);
			chk(region2, MAP[i].r2);
			if (MAP[i].r == 3'h1 || MAP[i].r == 3'h2) begin
				chk(core_bank_out, MAP[i].b);
			end
		end
	endtask : t_map
	task t_ctrl;
		logic [31:0] d;
		logic [1:0] r;
		int m;
		axr(8'h00, d, r);
		chk(d, 32'h00000000);
		axr(8'h04, d, r);
		chk(d, 32'h00008400);
		axw(8'h00, 32'h00000001, r);
		chk(r, 2'h0);
		cacc(2'h2, 24'h008000);
		chk(core_region_out, DMMD_RG_EXT);
		axr(8'h04, d, r);
		chk(d, 32'h00008000);
		axw(8'h00, 32'h00000002, r);
		cacc(2'h0, 24'h00F010);
		chk(core_region_out, DMMD_RG_PERIPH);
		for (m = 0; m < 4; m++) begin
			axw(8'h00, 32'(m << 4), r);
			cacc(2'h0, 24'(32'h010000 - m * 4096));
			chk(core_region_out, DMMD_RG_EXT);
			cacc(2'h0, 24'(32'h00FFFF - m * 4096));
			chk(core_region_out, DMMD_RG_RAM);
			axr(8'h04, d, r);
			chk(d, 32'h00008400 + m * 4096);
		end
		// out-of-range mode must leave the last mode in place
		axw(8'h00, 32'h00000040, r);
		axr(8'h00, d, r);
		chk(d, 32'h00000030);
		axw(8'h04, 32'hFFFFFFFF, r);
		chk(r, 2'h0);
		axr(8'h04, d, r);
		chk(d, 32'h0000B400);
		axw(8'h10, 32'h00000001, r);
		chk(r, 2'h2);
		axr(8'h10, d, r);
		chk(r, 2'h2);
		chk(d, 32'h00000000);
		axw(8'h00, 32'h00000000, r);
	endtask : t_ctrl
	// core holds its access for four samples; dma starts one cycle later
	task t_coll(input logic [1:0] cs, input logic [23:0] ca, input logic [1:0] ds,
		input logic [23:0] da, input int w, input logic [2:0] rx, input logic [4:0] bk);
		int n;
		@(posedge clk_in);
		go <= 1'b1;
		go_space <= dmmd_space_t'(ds);
		go_addr <= da;
		core_valid_in <= 1'b1;
		core_space_in <= dmmd_space_t'(cs);
		core_addr_in <= ca;
		@(posedge clk_in);
		go <= 1'b0;
		repeat (3) @(posedge clk_in);
		core_valid_in <= 1'b0;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_in);
			if (dma_valid_in !== 1'b1) begin
				break;
			end
		end
		if (n == 20) tmo();
		chk(waits, w);
		chk(served, rx);
		chk(sbank, bk);
		chk(srefused, rx == 3'h6);
	endtask : t_coll
	task t_dma;
		logic [31:0] d;
		logic [1:0] r;
		t_coll(2'h0, 24'h000800, 2'h0, 24'h000900, 3, 3'h1, 5'h01);
		t_coll(2'h0, 24'h000800, 2'h0, 24'h001000, 0, 3'h1, 5'h02);
		t_coll(2'h1, 24'h000800, 2'h0, 24'h000800, 0, 3'h1, 5'h01);
		t_coll(2'h2, 24'hFF0800, 2'h2, 24'hFF0FFF, 3, 3'h2, 5'h01);
		t_coll(2'h3, 24'h000000, 2'h2, 24'hFF0000, 0, 3'h6, 5'h00);
		axr(8'h08, d, r);
		chk(d, 32'h00000006);
		axr(8'h0C, d, r);
		chk(d, 32'h00000001);
	endtask : t_dma
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_in);
		chk(core_region_out, DMMD_RG_NONE);
		rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk(s_axi_awready, 32'h00000001);
		t_map();
		t_ctrl();
		t_dma();
		give_verdict();
	end
endmodule : dmmd_map_tb_top
